// ==== hdl/cfo_clock_flow.sv ====
// Configuration memory output stage: clock output, cascade, stall and decompression
`timescale 1ns/100ps
`include "cfo_params.svh"

module cfo_clock_flow #(
    parameter int DATA_W = 8,
    parameter int DEPTH  = 16,
    parameter int ADDR_W = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Configuration pins from the board
    input  wire logic              extClk,
    input  wire logic              chipEnableN,
    input  wire logic              outputEnableResetN,
    input  wire logic              busy,
    // Options fixed when the memory is programmed
    input  wire logic              cfgClkOutEn,
    input  wire logic              cfgUseOsc,
    input  wire logic              cfgOscSlow,
    input  wire logic              cfgDecompEn,
    // Programming write port into the store
    input  wire logic              progWe,
    input  wire logic [ADDR_W-1:0] progAddr,
    input  wire logic [DATA_W:0]   progData,
    // Configuration interface outputs
    output logic                   sourceSyncClockOut,
    output logic                   sourceSyncClockOutOe,
    output logic [DATA_W-1:0]      dataOut,
    output logic                   dataOe,
    output logic                   cascadeEnableOutN,
    output logic                   terminalCount
);

    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);
    localparam logic [`CFO_OSC_CNT_W-1:0] OSC_DEF_HALF  = `CFO_OSC_CNT_W'(`CFO_OSC_DEF_HALF);
    localparam logic [`CFO_OSC_CNT_W-1:0] OSC_SLOW_HALF = `CFO_OSC_CNT_W'(`CFO_OSC_SLOW_HALF);
    localparam logic [`CFO_TRAIL_CNT_W-1:0] TRAIL_DONE =
        `CFO_TRAIL_CNT_W'(`CFO_TRAIL_CYCLES);

    cfo_pkg::cfo_state_t state;
    cfo_pkg::cfo_state_t next_state;

    logic [DATA_W:0]              mem [DEPTH];
    logic [3:0]                   pinMeta;
    logic [3:0]                   pinSync;
    logic                         oeSync;
    logic                         ceSync;
    logic                         busyEff;
    logic [`CFO_OSC_CNT_W-1:0]    oscCnt;
    logic [`CFO_OSC_CNT_W-1:0]    oscHalf;
    logic                         oscLevel;
    logic                         srcLevel;
    logic                         srcPrev;
    logic                         riseTick;
    logic                         fallTick;
    logic [ADDR_W-1:0]            addr;
    logic                         wordValid;
    logic                         memEnd;
    logic                         phase;
    logic                         cycleLive;
    logic [`CFO_TRAIL_CNT_W-1:0]  trailCnt;
    logic                         advance;
    logic                         liveSlot;
    logic                         take;
    logic                         finishNow;
    logic                         decInValid;
    logic                         decInReady;
    logic                         decOutValid;
    logic [DATA_W-1:0]            decOutData;
    logic                         decOutReady;
    logic                         decIdle;

    // Programming writes into the store
    always_ff @(posedge clk) begin
        if (progWe) begin
            mem[progAddr] <= progData;
        end
    end

    // Two-stage synchronisers for every pin; only the second stage is read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinMeta <= `CFO_PIN_RST;
            pinSync <= `CFO_PIN_RST;
        end else begin
            pinMeta <= {extClk, busy, chipEnableN, outputEnableResetN};
            pinSync <= pinMeta;
        end
    end

    assign oeSync  = pinSync[`CFO_PIN_OE];
    assign ceSync  = pinSync[`CFO_PIN_CE];
    assign busyEff = pinSync[`CFO_PIN_BUSY] && !cfgDecompEn;

    // Internal oscillator, default or slow half period
    assign oscHalf = cfgOscSlow ? OSC_SLOW_HALF : OSC_DEF_HALF;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oscCnt   <= '0;
            oscLevel <= 1'b0;
        end else if (oscCnt >= oscHalf - 1'b1) begin
            oscCnt   <= '0;
            oscLevel <= !oscLevel;
        end else begin
            oscCnt   <= oscCnt + 1'b1;
        end
    end

    // Clock source select and edge detection
    assign srcLevel = cfgUseOsc ? oscLevel : pinSync[`CFO_PIN_EXT];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            srcPrev <= 1'b0;
        end else begin
            srcPrev <= srcLevel;
        end
    end
    assign riseTick = srcLevel && !srcPrev;
    assign fallTick = !srcLevel && srcPrev;

    // Words change on the falling source edge so they settle before the rise
    assign advance  = fallTick && (!wordValid || !busyEff);
    // Decompressed clock only uses every second source cycle
    assign liveSlot = fallTick && !phase;
    assign take     = liveSlot && decOutValid;
    assign finishNow = cfgDecompEn ? (liveSlot && terminalCount && !decOutValid)
                                   : (advance && terminalCount);

    // Expander fed straight from the store
    assign decInValid  = (state == cfo_pkg::ST_RUN) && cfgDecompEn && !memEnd;
    assign decOutReady = (state == cfo_pkg::ST_RUN) && cfgDecompEn && take;

    cfo_expander #(
        .DATA_W   (DATA_W)
    ) u_expander (
        .clk      (clk),
        .rstn     (rstn),
        .clr      (state != cfo_pkg::ST_RUN),
        .inValid  (decInValid),
        .inData   (mem[addr]),
        .inReady  (decInReady),
        .outValid (decOutValid),
        .outData  (decOutData),
        .outReady (decOutReady),
        .idle     (decIdle)
    );

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            cfo_pkg::ST_IDLE: begin
                if (oeSync && !ceSync) begin
                    next_state = cfo_pkg::ST_RUN;
                end
            end
            cfo_pkg::ST_RUN: begin
                if (!oeSync) begin
                    next_state = cfo_pkg::ST_IDLE;
                end else if (ceSync) begin
                    next_state = terminalCount ? cfo_pkg::ST_IDLE : cfo_pkg::ST_TRAIL;
                end else if (finishNow) begin
                    next_state = cfo_pkg::ST_DONE;
                end
            end
            cfo_pkg::ST_TRAIL: begin
                if (!oeSync) begin
                    next_state = cfo_pkg::ST_IDLE;
                end else if (fallTick && (trailCnt == TRAIL_DONE)) begin
                    // Leave on the fall after the last rise, so that rise reaches the pin
                    next_state = cfo_pkg::ST_IDLE;
                end
            end
            default: begin
                if (!oeSync || ceSync) begin
                    next_state = cfo_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= cfo_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Trailing cycle counter, counts clock rises after chip enable goes high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trailCnt <= '0;
        end else if (state != cfo_pkg::ST_TRAIL) begin
            trailCnt <= '0;
        end else if (riseTick) begin
            trailCnt <= trailCnt + 1'b1;
        end
    end

    // Address counter and word presentation
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr          <= '0;
            dataOut       <= '0;
            wordValid     <= 1'b0;
            terminalCount <= 1'b0;
            memEnd        <= 1'b0;
            phase         <= 1'b0;
        end else if (state == cfo_pkg::ST_IDLE) begin
            addr          <= '0;
            wordValid     <= 1'b0;
            terminalCount <= 1'b0;
            memEnd        <= 1'b0;
            phase         <= 1'b0;
        end else if ((state == cfo_pkg::ST_RUN) && !cfgDecompEn) begin
            // Busy holds both address and word; clock output is not touched
            if (advance && !terminalCount) begin
                dataOut   <= mem[addr][DATA_W-1:0];
                wordValid <= 1'b1;
                if (addr == LAST_ADDR) begin
                    terminalCount <= 1'b1;
                end else begin
                    addr <= addr + 1'b1;
                end
            end
        end else if ((state == cfo_pkg::ST_RUN) && cfgDecompEn) begin
            if (fallTick) begin
                phase <= !phase;
            end
            if (take) begin
                dataOut   <= decOutData;
                wordValid <= 1'b1;
            end
            // Store is read ahead while the expander has a free slot, so reads are paced by words taken on the output clock
            if (decInValid && decInReady) begin
                if (addr == LAST_ADDR) begin
                    memEnd <= 1'b1;
                end else begin
                    addr <= addr + 1'b1;
                end
            end
            if (memEnd && decIdle) begin
                terminalCount <= 1'b1;
            end
        end
    end

    // Clock output gating and pin enables
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cycleLive            <= 1'b0;
            sourceSyncClockOutOe <= 1'b0;
            dataOe               <= 1'b0;
        end else if ((next_state == cfo_pkg::ST_IDLE) || (next_state == cfo_pkg::ST_DONE)) begin
            // Leaving is immediate, no trailing cycles
            cycleLive            <= 1'b0;
            sourceSyncClockOutOe <= 1'b0;
            dataOe               <= 1'b0;
        end else if (next_state == cfo_pkg::ST_TRAIL) begin
            // Trailing clocks only; data floats once chip enable is high
            dataOe               <= 1'b0;
        end else if ((state == cfo_pkg::ST_RUN) && !cfgDecompEn) begin
            if (advance && !terminalCount) begin
                cycleLive            <= 1'b1;
                sourceSyncClockOutOe <= cfgClkOutEn;
                dataOe               <= 1'b1;
            end
        end else if ((state == cfo_pkg::ST_RUN) && cfgDecompEn) begin
            if (take) begin
                cycleLive            <= 1'b1;
                sourceSyncClockOutOe <= cfgClkOutEn;
                dataOe               <= 1'b1;
            end else if (liveSlot) begin
                cycleLive            <= 1'b0;
                sourceSyncClockOutOe <= 1'b0;
            end else if (fallTick) begin
                cycleLive            <= 1'b0;
            end
        end
    end

    // Clock output follows the source while the cycle is live
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sourceSyncClockOut <= 1'b0;
        end else begin
            sourceSyncClockOut <= srcLevel && cycleLive;
        end
    end

    // Cascade enable goes low only once this memory is done
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cascadeEnableOutN <= 1'b1;
        end else begin
            cascadeEnableOutN <= (next_state != cfo_pkg::ST_DONE);
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_idle_floats;
        (state == cfo_pkg::ST_IDLE) |=> !sourceSyncClockOutOe && !dataOe && cascadeEnableOutN;
    endproperty
    a_idle_floats: assert property (p_idle_floats)
        else $error("Outputs not floated in idle");

    property p_oe_fall_kills_clock;
        $fell(oeSync) |=> !sourceSyncClockOutOe && (state == cfo_pkg::ST_IDLE);
    endproperty
    a_oe_fall_kills_clock: assert property (p_oe_fall_kills_clock)
        else $error("Clock output not disabled at once on reset fall");

    property p_clk_only_when_enabled;
        sourceSyncClockOutOe |-> cfgClkOutEn && !cascadeEnableOutN == 1'b0;
    endproperty
    a_clk_only_when_enabled: assert property (p_clk_only_when_enabled)
        else $error("Clock output driven without option or while done");

    property p_trail_eight;
        (state == cfo_pkg::ST_TRAIL) && oeSync && fallTick && (trailCnt == TRAIL_DONE)
            |=> (state == cfo_pkg::ST_IDLE) && !sourceSyncClockOutOe;
    endproperty
    a_trail_eight: assert property (p_trail_eight)
        else $error("Trailing clock count wrong");

    property p_trail_floats_data;
        (state == cfo_pkg::ST_TRAIL) |-> !dataOe;
    endproperty
    a_trail_floats_data: assert property (p_trail_floats_data)
        else $error("Data driven while chip enable is high");

    property p_busy_holds;
        (state == cfo_pkg::ST_RUN) && busyEff && wordValid && !ceSync && oeSync
            |=> $stable(dataOut) && $stable(addr);
    endproperty
    a_busy_holds: assert property (p_busy_holds)
        else $error("Word or address moved while busy");

    property p_busy_clock_runs;
        (state == cfo_pkg::ST_RUN) && busyEff && sourceSyncClockOutOe && !ceSync && oeSync
            |=> sourceSyncClockOutOe && cycleLive;
    endproperty
    a_busy_clock_runs: assert property (p_busy_clock_runs)
        else $error("Clock output stopped while busy");

    property p_resume_advances;
        (state == cfo_pkg::ST_RUN) && !cfgDecompEn && fallTick && !busyEff && wordValid
            && !terminalCount && !ceSync && oeSync && (addr != LAST_ADDR)
            |=> addr == $past(addr) + 1'b1;
    endproperty
    a_resume_advances: assert property (p_resume_advances)
        else $error("Address did not advance after busy fell");

    property p_done_cascades;
        (state == cfo_pkg::ST_DONE) |-> !cascadeEnableOutN && !sourceSyncClockOutOe && !dataOe;
    endproperty
    a_done_cascades: assert property (p_done_cascades)
        else $error("Done memory still drives clock or holds cascade");

    property p_decomp_float;
        (state == cfo_pkg::ST_RUN) && cfgDecompEn && liveSlot && !decOutValid
            |=> !sourceSyncClockOutOe;
    endproperty
    a_decomp_float: assert property (p_decomp_float)
        else $error("Clock output driven with no decompressed word");

    property p_tc_stops;
        terminalCount && (state == cfo_pkg::ST_RUN) |=> $stable(addr);
    endproperty
    a_tc_stops: assert property (p_tc_stops)
        else $error("Address moved after terminal count");

    c_busy_stall: cover property ((state == cfo_pkg::ST_RUN) && busyEff && sourceSyncClockOutOe);
    c_trail: cover property ((state == cfo_pkg::ST_TRAIL) ##1 (state == cfo_pkg::ST_IDLE));
    c_done: cover property ($fell(cascadeEnableOutN));
    c_decomp_gap: cover property (cfgDecompEn && $fell(sourceSyncClockOutOe)
                                  && (state == cfo_pkg::ST_RUN));

endmodule : cfo_clock_flow

// ==== hdl/cfo_expander.sv ====
// Run-length expander that turns stored tokens into configuration words
`timescale 1ns/100ps

module cfo_expander #(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              clr,
    // Stored token stream: top bit set means repeat previous word
    input  wire logic              inValid,
    input  wire logic [DATA_W:0]   inData,
    output logic                   inReady,
    // Expanded words
    output logic                   outValid,
    output logic [DATA_W-1:0]      outData,
    input  wire logic              outReady,
    output logic                   idle
);

    logic [DATA_W-1:0] lastData;
    logic [DATA_W-1:0] repCount;
    logic              slotFree;

    // A slot is free when the output word is empty or being taken now
    assign slotFree = !outValid || outReady;
    // Tokens are only taken once pending repeats are spent, so order is kept
    assign inReady  = slotFree && (repCount == '0) && !clr;
    assign idle     = !outValid && (repCount == '0);

    // Expansion of literals and repeat tokens
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outValid <= 1'b0;
            outData  <= '0;
            lastData <= '0;
            repCount <= '0;
        end else if (clr) begin
            outValid <= 1'b0;
            repCount <= '0;
        end else if (slotFree && (repCount != '0)) begin
            outData  <= lastData;
            outValid <= 1'b1;
            repCount <= repCount - 1'b1;
        end else if (inValid && inReady) begin
            if (inData[DATA_W]) begin
                repCount <= inData[DATA_W-1:0];
                outValid <= 1'b0;
            end else begin
                outData  <= inData[DATA_W-1:0];
                lastData <= inData[DATA_W-1:0];
                outValid <= 1'b1;
            end
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end

endmodule : cfo_expander

// ==== hdl/cfo_params.svh ====
// Timing and reset constants for the configuration output clock flow block
`ifndef CFO_PARAMS_SVH
`define CFO_PARAMS_SVH

// System clock period
`define CFO_CLK_PERIOD_NS      10
// Internal oscillator periods, default and slow setting
`define CFO_OSC_DEF_PERIOD_NS  40
`define CFO_OSC_SLOW_PERIOD_NS 160
// Half periods of the oscillator in system clock cycles, never below one
`define CFO_OSC_DEF_HALF  (((`CFO_OSC_DEF_PERIOD_NS / 2) / `CFO_CLK_PERIOD_NS) > 0 ? \
                           ((`CFO_OSC_DEF_PERIOD_NS / 2) / `CFO_CLK_PERIOD_NS) : 1)
`define CFO_OSC_SLOW_HALF (((`CFO_OSC_SLOW_PERIOD_NS / 2) / `CFO_CLK_PERIOD_NS) > 0 ? \
                           ((`CFO_OSC_SLOW_PERIOD_NS / 2) / `CFO_CLK_PERIOD_NS) : 1)
// Oscillator counter width
`define CFO_OSC_CNT_W     4
// Extra clock output cycles after chip enable rises
`define CFO_TRAIL_CYCLES  8
`define CFO_TRAIL_CNT_W   4
// Reset value of pin synchronisers {extClk, busy, chipEnableN, outputEnableResetN}
`define CFO_PIN_RST       4'h2
// Bit positions in the pin synchroniser vector
`define CFO_PIN_OE        0
`define CFO_PIN_CE        1
`define CFO_PIN_BUSY      2
`define CFO_PIN_EXT       3

`endif

// ==== hdl/cfo_pkg.sv ====
// Types shared by the configuration output clock flow block
package cfo_pkg;

    // Output sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_TRAIL,
        ST_DONE
    } cfo_state_t;

endpackage : cfo_pkg

// ==== test/cfo_clock_flow_test.sv ====
// Self-checking bench for the configuration output clock flow block
`timescale 1ns/100ps

module cfo_clock_flow_test;
    localparam int DW = 8;
    localparam int DEPTH = 16;
    localparam int AW = 4;
    logic          clk, rstn, extClk, chipEnableN, outputEnableResetN, busy;
    logic          cfgClkOutEn, cfgUseOsc, cfgOscSlow, cfgDecompEn, progWe;
    logic [AW-1:0] progAddr;
    logic [DW:0]   progData;
    logic          source_sync_clock_out, clkOe, dataOe, casN, tc, stallReq, slaveMode, rise, wv, linkRun;
    logic [DW-1:0] dataOut, wd;
    logic [DW-1:0] expQ[$];
    int            numErrors, numChecks, nRise, riseMark, left, cycles, linkCnt;

    cfo_clock_flow #(.DATA_W(DW), .DEPTH(DEPTH)) uut (.clk(clk), .rstn(rstn), .extClk(extClk),
        .chipEnableN(chipEnableN), .outputEnableResetN(outputEnableResetN), .busy(busy),
        .cfgClkOutEn(cfgClkOutEn), .cfgUseOsc(cfgUseOsc), .cfgOscSlow(cfgOscSlow),
        .cfgDecompEn(cfgDecompEn), .progWe(progWe), .progAddr(progAddr), .progData(progData),
        .sourceSyncClockOut(source_sync_clock_out), .sourceSyncClockOutOe(clkOe), .dataOut(dataOut),
        .dataOe(dataOe), .cascadeEnableOutN(casN), .terminalCount(tc));
    cfo_receiver_model #(.DATA_W(DW)) model (.clk(clk), .rstn(rstn), .source_sync_clock_out(source_sync_clock_out),
        .clkOe(clkOe), .dataOut(dataOut), .dataOe(dataOe), .busy(busy), .stallReq(stallReq),
        .slaveMode(slaveMode), .risePulse(rise), .wordValid(wv), .wordData(wd));

    task automatic finishTest();
        $display("Checks %0d errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finishTest

    task automatic checkBit(input string what, input logic exp, input logic got);
        numChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : checkBit

    task automatic checkWord(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        numChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : checkWord

    // Fill the store and note the words the receiver should see, repeats expanded
    task automatic loadStore(input bit comp);
        logic [DW-1:0] lit;
        logic [DW:0]   tok;
        expQ.delete();
        for (int a = 0; a < DEPTH; a++) begin
            @(negedge clk);
            tok = {1'b0, DW'($urandom)};
            if (comp && a > 0 && $urandom_range(1) == 1) tok = {1'b1, DW'($urandom_range(3))};
            if (!tok[DW]) lit = tok[DW-1:0];
            repeat (tok[DW] ? int'(tok[DW-1:0]) : 1) expQ.push_back(lit);
            progWe = 1'b1;
            progAddr = AW'(a);
            progData = tok;
        end
        @(negedge clk);
        progWe = 1'b0;
    endtask : loadStore

    task automatic start();
        @(negedge clk);
        chipEnableN = 1'b0;
        outputEnableResetN = 1'b1;
        linkRun = 1'b1;
    endtask : start

    task automatic stop();
        @(negedge clk);
        chipEnableN = 1'b1;
        linkRun = 1'b0;
        repeat (10) @(negedge clk);
    endtask : stop

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Link clock of 160 ns, moved on the falling system edge, still outside frames
    always @(negedge clk) begin
        if (linkRun) linkCnt = linkCnt + 1;
        if (linkCnt == 8) begin
            extClk = ~extClk;
            linkCnt = 0;
        end
    end

    // Each taken word is matched against the oldest note; a hang ends the run
    always @(posedge clk) begin
        cycles++;
        if (rise) nRise++;
        if (wv) checkWord("word", expQ.size() > 0 ? expQ.pop_front() : {DW{1'bx}}, wd);
        if (cycles == 30000) begin
            numErrors++;
            $display("Error timeout expected finish seen hang");
            finishTest();
        end
    end

    initial begin
        {rstn, extClk, linkRun, stallReq, slaveMode, progWe, progAddr, progData} = '0;
        {cfgUseOsc, cfgOscSlow, cfgDecompEn, linkCnt} = '0;
        {chipEnableN, outputEnableResetN, cfgClkOutEn} = 3'h7;
        void'($urandom(32'hF327));
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        // Full stream from the clock pin with a receiver stall in the middle
        loadStore(0);
        checkBit("clock oe before enable", 1'b0, clkOe);
        start();
        for (int i = 0; i < 3000 && expQ.size() > 10; i++) @(negedge clk);
        stallReq = 1'b1;
        riseMark = nRise;
        left = expQ.size();
        repeat (80) @(negedge clk);
        checkBit("clock while busy", 1'b1, nRise > riseMark + 3);
        checkBit("held while busy", 1'b1, expQ.size() >= left - 1);
        stallReq = 1'b0;
        for (int i = 0; i < 3000 && expQ.size() > 0; i++) @(negedge clk);
        checkBit("terminal count", 1'b1, tc);
        for (int i = 0; i < 100 && casN !== 1'b0; i++) @(negedge clk);
        checkBit("cascade when done", 1'b0, casN);
        checkBit("clock oe when done", 1'b0, clkOe);
        stop();
        checkBit("cascade after disable", 1'b1, casN);
        // Chip enable rises mid-stream: trailing clocks, then float
        loadStore(0);
        start();
        for (int i = 0; i < 3000 && expQ.size() > 8; i++) @(negedge clk);
        @(negedge extClk);
        @(negedge clk);
        chipEnableN = 1'b1;
        riseMark = nRise;
        for (int i = 0; i < 400 && clkOe !== 1'b0; i++) @(negedge clk);
        repeat (40) @(negedge clk);
        checkBit("trailing clocks", 1'b1, nRise - riseMark == 8);
        checkBit("data oe after trail", 1'b0, dataOe);
        stop();
        // Reset line falls mid-stream: clock off at once
        loadStore(0);
        start();
        for (int i = 0; i < 3000 && expQ.size() > 12; i++) @(negedge clk);
        outputEnableResetN = 1'b0;
        repeat (4) @(negedge clk);
        checkBit("clock oe at reset", 1'b0, clkOe);
        riseMark = nRise;
        repeat (40) @(negedge clk);
        checkBit("no clocks in reset", 1'b1, nRise == riseMark);
        checkBit("cascade in reset", 1'b1, casN);
        stop();
        // Clock option off: words still step, the clock pin is never driven
        cfgClkOutEn = 1'b0;
        start();
        repeat (60) @(negedge clk);
        checkBit("clock oe with option off", 1'b0, clkOe);
        checkBit("data with option off", 1'b1, dataOe);
        stop();
        cfgClkOutEn = 1'b1;
        // Expanded streams from both oscillator rates; busy forced high is ignored
        {cfgDecompEn, cfgUseOsc, slaveMode, stallReq} = 4'hF;
        for (int s = 0; s < 2; s++) begin
            cfgOscSlow = s[0];
            loadStore(1);
            start();
            linkRun = 1'b0;
            for (int i = 0; i < 8000 && casN !== 1'b0; i++) @(negedge clk);
            checkBit("expanded stream done", 1'b0, casN);
            checkBit("all words taken", 1'b1, expQ.size() == 0);
            stop();
        end
        finishTest();
    end
endmodule : cfo_clock_flow_test

// ==== test/cfo_receiver_model.sv ====
// Receiver model: slave configuration target clocked by the device clock output
`timescale 1ns/100ps

module cfo_receiver_model #(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Device pins
    input  wire logic              source_sync_clock_out,
    input  wire logic              clkOe,
    input  wire logic [DATA_W-1:0] dataOut,
    input  wire logic              dataOe,
    output logic                   busy,
    // Bench control and report
    input  wire logic              stallReq,
    input  wire logic              slaveMode,
    output logic                   risePulse,
    output logic                   wordValid,
    output logic [DATA_W-1:0]      wordData
);
    logic drv;
    logic prevDrv;

    // Only driven edges count; a pull-up rise on a floating pin is not a clock
    assign drv = clkOe & source_sync_clock_out;

    // Take a word on each rising clock edge while data is driven and busy is low or slaveMode is set; busy moves just after a rise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prevDrv <= 1'b0;
            busy <= 1'b0;
            risePulse <= 1'b0;
            wordValid <= 1'b0;
            wordData <= '0;
        end else begin
            prevDrv <= drv;
            risePulse <= drv & ~prevDrv;
            wordValid <= drv & ~prevDrv & dataOe & (slaveMode | ~busy);
            wordData <= dataOut;
            if (drv & ~prevDrv) busy <= stallReq;
        end
    end
endmodule : cfo_receiver_model
